//--- rtl/dsm_consts.vh
// Constants for the decoder sync and mute control block
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
// Register byte offsets
`define DSM_OFS_CTRL      8'h00
`define DSM_OFS_SETUP     8'h04
`define DSM_OFS_MODE      8'h08
`define DSM_OFS_NOISE     8'h0C
`define DSM_OFS_STATUS    8'h10
`define DSM_OFS_COMP0     8'h14
`define DSM_OFS_COMP1     8'h18
`define DSM_OFS_SCALE     8'h1C
// CTRL fields
`define DSM_CTRL_MUTE     0
`define DSM_CTRL_DEEMPH   1
`define DSM_CTRL_RESET    32'h0000_0001
// SETUP fields (set once)
`define DSM_SU_CLKMODE    0
`define DSM_SU_DUAL       1
`define DSM_SU_ROLE       2
`define DSM_SU_LOCK_LO    4
`define DSM_SU_BURST      7
`define DSM_SU_RST_LO     8
`define DSM_SETUP_RESET   32'h0000_0010
// MODE fields
`define DSM_MD_PAY_LO     0
`define DSM_MD_MAT_LO     2
`define DSM_MD_INLEN_LO   4
`define DSM_MD_OUTLEN_LO  6
`define DSM_MD_PORT_LO    8
// Sync states, one-hot
`define DSM_ST_OOS        3'b001
`define DSM_ST_LMUTE      3'b010
`define DSM_ST_DEC        3'b100
// Operating modes
`define DSM_OM_IDLE       3'h0
`define DSM_OM_CMP_MTX    3'h1
`define DSM_OM_CMP        3'h2
`define DSM_OM_PCM_MTX    3'h3
`define DSM_OM_PCM_THRU   3'h4
`define DSM_OM_NOISE      3'h5
// Timing
`define DSM_INIT_TIME_NS  200000
`define DSM_CLK_PERIOD_NS 4
`define DSM_INIT_CYCLES   (`DSM_INIT_TIME_NS / `DSM_CLK_PERIOD_NS)
`define DSM_RAMP_SAMPLES  9'd256
`define DSM_LINK_BITS     6'd36
`define DSM_FS_DIV        256
`endif

//--- rtl/dsm_ctrl.v
// Sync state machine, mute control, mode select and compression link
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`include "dsm_consts.vh"
module dsm_ctrl #(
  parameter INIT_CYCLES = `DSM_INIT_CYCLES
) (
  // Clock, reset, enable
  input  wire        CLK,
  input  wire        RST,
  input  wire        CE,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // Decoder core events, same clock
  input  wire        SYNC_OK,
  input  wire        SYNC_MISS,
  input  wire        STREAM_ERR,
  input  wire [1:0]  SURR_FLAG,
  input  wire        PREAMBLE_SEEN,
  input  wire        SAMPLE_TICK,
  input  wire        FRAME_START,
  input  wire [17:0] LOCAL_COMP,
  input  wire [17:0] LOCAL_COMP_B,
  // Pins from outside
  input  wire        EXTERNAL_MUTE_PIN_N,
  input  wire        SYNC_RESTART_PIN,
  input  wire        DEEMPH_PIN,
  // Compression link pins
  input  wire        COMPRESSION_LINK_CLOCK_I,
  output reg         COMPRESSION_LINK_CLOCK_O,
  output reg         COMPRESSION_LINK_CLOCK_OE,
  input  wire        COMPRESSION_LINK_DATA_I,
  output reg         COMPRESSION_LINK_DATA_O,
  output reg         COMPRESSION_LINK_DATA_OE,
  input  wire        FRAME_OUTPUT_SYNC_I,
  output reg         FRAME_OUTPUT_SYNC_O,
  output reg         FRAME_OUTPUT_SYNC_OE,
  // Status outputs
  output reg         PAYLOAD_TYPE_INDICATOR,
  output reg         SYNC_LOCKED,
  output reg         OUT_MUTE,
  output reg  [8:0]  MUTE_GAIN,
  output reg  [2:0]  OP_MODE,
  output reg         DEEMPH_ON,
  output reg         INIT_BUSY
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word length code to bits: 00=16 01=18 10=20 11=24
  function [4:0] wlen;
    input [1:0] c;
    begin
      case (c)
        2'b00:   wlen = 5'd16;
        2'b01:   wlen = 5'd18;
        2'b10:   wlen = 5'd20;
        default: wlen = 5'd24;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [1:0] mute_s_r;
  reg [1:0] rst_s_r;
  reg [1:0] dem_s_r;
  reg [1:0] lck_s_r;
  reg [1:0] ldat_s_r;
  reg [1:0] fsy_s_r;
  reg       lck_d_r;
  reg       fsy_d_r;

  // Two flops per pin; the second stage feeds logic, and a third flop on link clock and frame sync finds their rises
  always @(posedge CLK) begin
    if (RST) begin
      mute_s_r <= 2'b11;
      rst_s_r  <= 2'b00;
      dem_s_r  <= 2'b00;
      lck_s_r  <= 2'b11;   // Link clock idles high; avoids a false rise
      ldat_s_r <= 2'b11;
      fsy_s_r  <= 2'b00;
      lck_d_r  <= 1'b1;
      fsy_d_r  <= 1'b0;
    end else if (CE) begin
      mute_s_r <= {mute_s_r[0], EXTERNAL_MUTE_PIN_N};
      rst_s_r  <= {rst_s_r[0], SYNC_RESTART_PIN};
      dem_s_r  <= {dem_s_r[0], DEEMPH_PIN};
      lck_s_r  <= {lck_s_r[0], COMPRESSION_LINK_CLOCK_I};
      ldat_s_r <= {ldat_s_r[0], COMPRESSION_LINK_DATA_I};
      fsy_s_r  <= {fsy_s_r[0], FRAME_OUTPUT_SYNC_I};
      lck_d_r  <= lck_s_r[1];
      fsy_d_r  <= fsy_s_r[1];
    end
  end

  wire lck_rise = lck_s_r[1] & ~lck_d_r;
  wire fsy_rise = fsy_s_r[1] & ~fsy_d_r;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl_r;
  reg [31:0] setup_r;
  reg [10:0] mode_r;
  reg [5:0]  noise_r;
  reg [30:0] scale_r;
  reg        setup_wr_r;
  reg [35:0] rx_word_r;
  reg        rx_new_r;
  reg [15:0] init_cnt_r;
  reg [2:0]  st_r;
  reg [2:0]  ok_cnt_r;
  reg        miss1_r;
  reg        auto_cmp_r;
  reg        pre_mute_r;
  reg [2:0]  mode_prev_r;
  reg        mode_mute_r;

  wire       dual_en   = setup_r[`DSM_SU_DUAL];
  wire       is_sub    = setup_r[`DSM_SU_ROLE];
  wire [2:0] lock_n    = setup_r[`DSM_SU_LOCK_LO+2:`DSM_SU_LOCK_LO];
  wire [1:0] rst_sel   = setup_r[`DSM_SU_RST_LO+1:`DSM_SU_RST_LO];
  wire [1:0] pay_sel   = mode_r[`DSM_MD_PAY_LO+1:`DSM_MD_PAY_LO];
  wire [1:0] mat_sel   = mode_r[`DSM_MD_MAT_LO+1:`DSM_MD_MAT_LO];
  wire       demux_in  = mode_r[`DSM_MD_PORT_LO+1];
  wire [4:0] in_bits   = wlen(mode_r[`DSM_MD_INLEN_LO+1:`DSM_MD_INLEN_LO]);
  wire [4:0] out_bits  = wlen(mode_r[`DSM_MD_OUTLEN_LO+1:`DSM_MD_OUTLEN_LO]);

  // AHB-Lite address phase capture; answer is zero-wait
  reg        ap_wr_r;
  reg [7:0]  ap_addr_r;
  wire       ap_valid = HSEL & HTRANS[1];
  wire       host_ok  = ~INIT_BUSY;

  // Register writes; set-once settings lock after first write
  always @(posedge CLK) begin
    if (RST) begin
      ap_wr_r    <= 1'b0;
      ap_addr_r  <= 8'h00;
      ctrl_r     <= `DSM_CTRL_RESET;
      setup_r    <= `DSM_SETUP_RESET;
      mode_r     <= 11'h000;
      noise_r    <= 6'h00;
      scale_r    <= {15'h0000, 16'h0000};
      setup_wr_r <= 1'b0;
    end else if (CE) begin
      ap_wr_r   <= ap_valid & HWRITE;
      ap_addr_r <= HADDR[7:0];
      if (ap_wr_r && host_ok) begin
        case (ap_addr_r)
          `DSM_OFS_CTRL:  ctrl_r <= {30'h0, HWDATA[1:0]};
          `DSM_OFS_SETUP: if (!setup_wr_r) begin
            setup_r    <= {22'h0, HWDATA[9:0]};
            setup_wr_r <= 1'b1;
          end
          `DSM_OFS_MODE:  mode_r  <= HWDATA[10:0];
          `DSM_OFS_NOISE: noise_r <= HWDATA[5:0];
          // High/low scale masked with 7F, dialog with 7FFF
          `DSM_OFS_SCALE: scale_r <= {HWDATA[30:24] & 7'h7F, HWDATA[23:16] & 8'h7F, 1'b0,
                                      HWDATA[14:0]};
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped reads as zero, response always OKAY
  reg [31:0] rd_nxt;
  always @* begin
    case (HADDR[7:0])
      `DSM_OFS_CTRL:   rd_nxt = ctrl_r;
      `DSM_OFS_SETUP:  rd_nxt = setup_r;
      `DSM_OFS_MODE:   rd_nxt = {21'h0, mode_r};
      `DSM_OFS_NOISE:  rd_nxt = {26'h0, noise_r};
      `DSM_OFS_STATUS: rd_nxt = {out_bits, in_bits, 11'h000, OP_MODE, OUT_MUTE, auto_cmp_r, INIT_BUSY, st_r, 1'b0,
                                 rx_new_r};
      `DSM_OFS_COMP0:  rd_nxt = {14'h0, rx_word_r[17:0]};
      `DSM_OFS_COMP1:  rd_nxt = {14'h0, rx_word_r[35:18]};
      `DSM_OFS_SCALE:  rd_nxt = {1'b0, scale_r};
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CE) begin
      if (ap_valid && !HWRITE)
        HRDATA <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Initialisation timer
  // ----------------------------------------------------------------
  // Host writes are dropped until this count expires
  always @(posedge CLK) begin
    if (RST) begin
      init_cnt_r <= 16'h0000;
      INIT_BUSY  <= 1'b1;
    end else if (CE && INIT_BUSY) begin
      if (init_cnt_r == INIT_CYCLES[15:0] - 16'h0001)
        INIT_BUSY <= 1'b0;
      init_cnt_r <= init_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Sync state machine
  // ----------------------------------------------------------------
  wire mute_req = ~mute_s_r[1] | ctrl_r[`DSM_CTRL_MUTE] | STREAM_ERR | pre_mute_r | mode_mute_r;
  wire restart  = rst_s_r[1] & (rst_sel == 2'b01 || rst_sel == 2'b10);

  always @(posedge CLK) begin
    if (RST) begin
      st_r     <= `DSM_ST_OOS;
      ok_cnt_r <= 3'h0;
      miss1_r  <= 1'b0;
    end else if (CE) begin
      case (st_r)
        `DSM_ST_OOS: begin
          miss1_r <= 1'b0;
          if (SYNC_MISS)
            ok_cnt_r <= 3'h0;
          else if (SYNC_OK) begin
            if (ok_cnt_r + 3'h1 >= lock_n) begin
              ok_cnt_r <= 3'h0;
              st_r     <= mute_req ? `DSM_ST_LMUTE : `DSM_ST_DEC;
            end else
              ok_cnt_r <= ok_cnt_r + 3'h1;
          end
        end
        `DSM_ST_LMUTE, `DSM_ST_DEC: begin
          if (restart) begin
            st_r <= `DSM_ST_OOS;
          end else if (SYNC_MISS && miss1_r) begin
            st_r <= `DSM_ST_OOS;
          end else begin
            if (SYNC_MISS)
              miss1_r <= 1'b1;
            else if (SYNC_OK)
              miss1_r <= 1'b0;
            st_r <= mute_req ? `DSM_ST_LMUTE : `DSM_ST_DEC;
          end
        end
        default: st_r <= `DSM_ST_OOS;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Payload detect and operating mode
  // ----------------------------------------------------------------
  reg [2:0] om_nxt;
  wire cmp_act = (pay_sel == 2'b00 && auto_cmp_r) || pay_sel == 2'b01 || demux_in;
  wire pcm_act = ~demux_in & ((pay_sel == 2'b00 && !auto_cmp_r) || pay_sel[1]);

  always @* begin
    if (|noise_r)
      om_nxt = `DSM_OM_NOISE;
    else if (cmp_act && (mat_sel == 2'b01 || (mat_sel == 2'b10 && SURR_FLAG == 2'b10)))
      om_nxt = `DSM_OM_CMP_MTX;
    else if (cmp_act && (mat_sel == 2'b00 || mat_sel == 2'b10))
      om_nxt = `DSM_OM_CMP;
    else if (pcm_act && mat_sel == 2'b01)
      om_nxt = `DSM_OM_PCM_MTX;
    else if (pcm_act && mat_sel == 2'b00)
      om_nxt = `DSM_OM_PCM_THRU;
    else
      om_nxt = `DSM_OM_IDLE;
  end

  // Preamble search result; mode change and forced-PCM preamble mute
  always @(posedge CLK) begin
    if (RST) begin
      auto_cmp_r             <= 1'b0;
      pre_mute_r             <= 1'b0;
      mode_prev_r            <= `DSM_OM_IDLE;
      mode_mute_r            <= 1'b0;
      OP_MODE                <= `DSM_OM_IDLE;
      PAYLOAD_TYPE_INDICATOR <= 1'b0;
      DEEMPH_ON              <= 1'b0;
    end else if (CE) begin
      if (pay_sel == 2'b00 && PREAMBLE_SEEN)
        auto_cmp_r <= 1'b1;
      else if (pay_sel == 2'b00 && FRAME_START && !PREAMBLE_SEEN)
        auto_cmp_r <= 1'b0;
      PAYLOAD_TYPE_INDICATOR <= auto_cmp_r;
      if (pay_sel == 2'b10 && PREAMBLE_SEEN)
        pre_mute_r <= 1'b1;
      else if (pay_sel != 2'b10 || FRAME_START)
        pre_mute_r <= 1'b0;
      mode_prev_r <= om_nxt;
      OP_MODE     <= om_nxt;
      // Mute held until the ramp has fully closed, then released
      if (om_nxt != mode_prev_r)
        mode_mute_r <= 1'b1;
      else if (MUTE_GAIN == 9'd0)
        mode_mute_r <= 1'b0;
      DEEMPH_ON <= pcm_act & (ctrl_r[`DSM_CTRL_DEEMPH] | dem_s_r[1]);
    end
  end

  // ----------------------------------------------------------------
  // Mute ramp
  // ----------------------------------------------------------------
  // One step per sample in compressed modes; all other modes switch at once
  wire want_mute = ~st_r[2];
  always @(posedge CLK) begin
    if (RST) begin
      OUT_MUTE    <= 1'b1;
      SYNC_LOCKED <= 1'b0;
      MUTE_GAIN   <= 9'd0;
    end else if (CE) begin
      OUT_MUTE    <= want_mute;
      SYNC_LOCKED <= ~st_r[0];
      if (OP_MODE == `DSM_OM_CMP || OP_MODE == `DSM_OM_CMP_MTX) begin
        if (SAMPLE_TICK && want_mute && MUTE_GAIN != 9'd0)
          MUTE_GAIN <= MUTE_GAIN - 9'd1;
        else if (SAMPLE_TICK && !want_mute && MUTE_GAIN != `DSM_RAMP_SAMPLES)
          MUTE_GAIN <= MUTE_GAIN + 9'd1;
      end else
        MUTE_GAIN <= want_mute ? 9'd0 : `DSM_RAMP_SAMPLES;
    end
  end

  // ----------------------------------------------------------------
  // Compression link and frame sync
  // ----------------------------------------------------------------
  reg [5:0]  tx_cnt_r;
  reg [37:0] tx_sh_r;
  reg [2:0]  div_r;
  reg [5:0]  rx_cnt_r;
  reg [1:0]  rx_zero_r;
  reg        rx_busy_r;

  // Sub sends; main receives; main drives frame sync
  always @(posedge CLK) begin
    if (RST) begin
      tx_cnt_r                  <= 6'd0;
      tx_sh_r                   <= 38'h0;
      div_r                     <= 3'd0;
      rx_cnt_r                  <= 6'd0;
      rx_zero_r                 <= 2'd0;
      rx_busy_r                 <= 1'b0;
      rx_word_r                 <= 36'h0;
      rx_new_r                  <= 1'b0;
      COMPRESSION_LINK_CLOCK_O  <= 1'b1;
      COMPRESSION_LINK_CLOCK_OE <= 1'b0;
      COMPRESSION_LINK_DATA_O   <= 1'b1;
      COMPRESSION_LINK_DATA_OE  <= 1'b0;
      FRAME_OUTPUT_SYNC_O       <= 1'b0;
      FRAME_OUTPUT_SYNC_OE      <= 1'b0;
    end else if (CE) begin
      COMPRESSION_LINK_CLOCK_OE <= dual_en & is_sub;
      COMPRESSION_LINK_DATA_OE  <= dual_en & is_sub;
      FRAME_OUTPUT_SYNC_OE      <= dual_en & ~is_sub;
      // Sub: start packet on frame sync rise, divided clock
      if (dual_en && is_sub) begin
        div_r <= div_r + 3'd1;
        if (tx_cnt_r == 6'd0 && fsy_rise) begin
          tx_sh_r  <= {2'b00, LOCAL_COMP_B, LOCAL_COMP};
          tx_cnt_r <= 6'd38;
          div_r    <= 3'd0;
        end else if (tx_cnt_r != 6'd0 && div_r == 3'd3) begin
          COMPRESSION_LINK_CLOCK_O <= 1'b0;
          COMPRESSION_LINK_DATA_O  <= tx_sh_r[37];
          tx_sh_r                  <= {tx_sh_r[36:0], 1'b1};
        end else if (tx_cnt_r != 6'd0 && div_r == 3'd7) begin
          COMPRESSION_LINK_CLOCK_O <= 1'b1;
          tx_cnt_r                 <= tx_cnt_r - 6'd1;
        end else if (tx_cnt_r == 6'd0)
          COMPRESSION_LINK_DATA_O <= 1'b1;
      end
      // Main: two zeros then 36 bits on link clock rise
      if (dual_en && !is_sub && lck_rise) begin
        if (!rx_busy_r) begin
          rx_zero_r <= ldat_s_r[1] ? 2'd0 : rx_zero_r + 2'd1;
          if (!ldat_s_r[1] && rx_zero_r == 2'd1) begin
            rx_busy_r <= 1'b1;
            rx_cnt_r  <= 6'd0;
            rx_zero_r <= 2'd0;
          end
        end else begin
          rx_word_r <= {rx_word_r[34:0], ldat_s_r[1]};
          rx_cnt_r  <= rx_cnt_r + 6'd1;
          if (rx_cnt_r == `DSM_LINK_BITS - 6'd1) begin
            rx_busy_r <= 1'b0;
            rx_new_r  <= 1'b1;
          end
        end
      end
      if (ap_valid && !HWRITE && HADDR[7:0] == `DSM_OFS_COMP1 && !(rx_busy_r && rx_cnt_r == 6'd35 && lck_rise))
        rx_new_r <= 1'b0;
      // Main: frame sync pulse one cycle after the core's frame start
      FRAME_OUTPUT_SYNC_O <= dual_en & ~is_sub & FRAME_START;
    end
  end

endmodule // dsm_ctrl

//--- tb/dsm_ctrl_assertions.sv
// Concurrent checks on the ports of the sync and mute control block
module dsm_ctrl_assertions #(
  parameter INIT_CYCLES = 20
) (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Bus answer
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  // Core events and pins
  input wire logic       SYNC_OK,
  input wire logic       SYNC_MISS,
  input wire logic       STREAM_ERR,
  input wire logic       FRAME_START,
  input wire logic       EXTERNAL_MUTE_PIN_N,
  // Outputs under watch
  input wire logic       FRAME_OUTPUT_SYNC_O,
  input wire logic       FRAME_OUTPUT_SYNC_OE,
  input wire logic       SYNC_LOCKED,
  input wire logic       OUT_MUTE,
  input wire logic [8:0] MUTE_GAIN,
  input wire logic [2:0] OP_MODE,
  input wire logic       INIT_BUSY
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Cycles spent in initialisation; a stuck or early busy flag shows here
  logic [15:0] cnt_r;
  always @(posedge CLK) begin
    if (RST) begin
      cnt_r <= 16'h0000;
    end else if (INIT_BUSY) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus slave stalled or answered with an error");
  AST_INIT_MUTE: assert property ($fell(RST) |-> OUT_MUTE && INIT_BUSY)
    else $error("output not muted or init not busy after reset");
  AST_INIT_LEN: assert property ($fell(INIT_BUSY) |-> cnt_r >= INIT_CYCLES && cnt_r <= INIT_CYCLES + 1)
    else $error("initialisation length wrong");
  AST_OOS_MUTED: assert property (!SYNC_LOCKED && !$past(SYNC_LOCKED) |-> OUT_MUTE)
    else $error("output live while out of sync");
  AST_LOCK_CAUSE: assert property ($rose(SYNC_LOCKED) |-> $past(SYNC_OK) || $past(SYNC_OK, 2))
    else $error("lock gained without a sync word");
  AST_SYNC_DROP: assert property (SYNC_LOCKED && SYNC_MISS ##1 SYNC_MISS |-> ##[1:3] !SYNC_LOCKED)
    else $error("lock kept after two misses");
  AST_EXT_MUTE: assert property (!EXTERNAL_MUTE_PIN_N [*5] |-> OUT_MUTE)
    else $error("mute pin ignored");
  AST_ERR_MUTE: assert property (STREAM_ERR [*3] |-> OUT_MUTE)
    else $error("stream error did not mute");
  AST_MODE_MUTE: assert property ($changed(OP_MODE) |-> ##[0:2] OUT_MUTE)
    else $error("mode change without mute");
  AST_FRAME_SYNC: assert property (FRAME_OUTPUT_SYNC_OE |=> FRAME_OUTPUT_SYNC_O == $past(FRAME_START))
    else $error("frame sync not one cycle after frame start");
  AST_GAIN_RANGE: assert property (MUTE_GAIN <= 9'h100)
    else $error("mute gain above full scale");

  // Main scenarios reached
  cover property ($rose(SYNC_LOCKED));
  cover property ($fell(SYNC_LOCKED));
  cover property (OP_MODE == 3'h5);
endmodule // dsm_ctrl_assertions

bind dsm_ctrl dsm_ctrl_assertions #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .CLK(CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SYNC_OK(SYNC_OK),
  .SYNC_MISS(SYNC_MISS), .STREAM_ERR(STREAM_ERR), .FRAME_START(FRAME_START),
  .EXTERNAL_MUTE_PIN_N(EXTERNAL_MUTE_PIN_N), .FRAME_OUTPUT_SYNC_O(FRAME_OUTPUT_SYNC_O),
  .FRAME_OUTPUT_SYNC_OE(FRAME_OUTPUT_SYNC_OE), .SYNC_LOCKED(SYNC_LOCKED), .OUT_MUTE(OUT_MUTE),
  .MUTE_GAIN(MUTE_GAIN), .OP_MODE(OP_MODE), .INIT_BUSY(INIT_BUSY));

//--- tb/dsm_sub_model.sv
// Sub chip model that sends compression parameters over the link
module dsm_sub_model (
  // Link pins, driven by the sub chip
  output logic link_clk,
  output logic link_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock stands high between frames; data idles high so start bits stand out
  initial begin
    link_clk = 1'b1;
    link_data = 1'b1;
  end

  // Two zero start bits, then 36 bits MSB first; 48 ns per bit
  task send(input logic [35:0] d, input int gap);
    logic [37:0] f;
    f = {2'b00, d};
    #(gap);
    for (int i = 37; i >= 0; i--) begin
      #24 link_clk = 1'b0;
      link_data = f[i];
      #24 link_clk = 1'b1;
    end
    #24 link_data = 1'b1;
  endtask
endmodule // dsm_sub_model

//--- tb/tb.sv
// Testbench for the sync, mute, mode and link control block
`include "dsm_consts.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, sync_ok = 1'b0, sync_miss = 1'b0;
  logic        stream_err = 1'b0, preamble = 1'b0, tick = 1'b0, frame_start = 1'b0;
  logic        mute_n = 1'b1, restart = 1'b0, deemph = 1'b0;
  logic [1:0]  htrans = 2'h0, surr = 2'h0;
  logic [7:0]  tcnt = 8'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  wire  [31:0] hrdata;
  wire         hready, hresp, cl_o, cl_oe, cd_o, cd_oe, fs_o, fs_oe, m_clk, m_dat;
  wire         pti, locked, omute, deemph_on, init_busy;
  wire  [8:0]  gain;
  wire  [2:0]  op_mode;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  localparam logic [31:0] OOS = 32'h04, LMU = 32'h08, DEC = 32'h10;
  // Pin levels resolved from the DUT's output enables
  wire link_clk = cl_oe ? cl_o : m_clk;
  wire link_dat = cd_oe ? cd_o : m_dat;
  wire fs_line  = fs_oe ? fs_o : 1'b0;

  dsm_ctrl #(.INIT_CYCLES(20)) u_dut (
    .CLK(clk), .RST(rst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .SYNC_OK(sync_ok), .SYNC_MISS(sync_miss), .STREAM_ERR(stream_err), .SURR_FLAG(surr),
    .PREAMBLE_SEEN(preamble), .SAMPLE_TICK(tick), .FRAME_START(frame_start),
    .LOCAL_COMP(18'h00000), .LOCAL_COMP_B(18'h00000), .EXTERNAL_MUTE_PIN_N(mute_n),
    .SYNC_RESTART_PIN(restart), .DEEMPH_PIN(deemph), .COMPRESSION_LINK_CLOCK_I(link_clk),
    .COMPRESSION_LINK_CLOCK_O(cl_o), .COMPRESSION_LINK_CLOCK_OE(cl_oe), .COMPRESSION_LINK_DATA_I(link_dat),
    .COMPRESSION_LINK_DATA_O(cd_o), .COMPRESSION_LINK_DATA_OE(cd_oe), .FRAME_OUTPUT_SYNC_I(fs_line),
    .FRAME_OUTPUT_SYNC_O(fs_o), .FRAME_OUTPUT_SYNC_OE(fs_oe), .PAYLOAD_TYPE_INDICATOR(pti),
    .SYNC_LOCKED(locked), .OUT_MUTE(omute), .MUTE_GAIN(gain), .OP_MODE(op_mode),
    .DEEMPH_ON(deemph_on), .INIT_BUSY(init_busy));

  dsm_sub_model u_sub (.link_clk(m_clk), .link_data(m_dat));

  always #2 clk = ~clk;

  // Sample ticks, frame starts and the hang limit
  always @(posedge clk) begin
    tcnt <= tcnt + 8'h01;
    tick <= (tcnt[1:0] == 2'h0);
    frame_start <= (tcnt == 8'h00);
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test;
    end
  end

  // ------------------------------------------------------------
  // Bus and helper tasks; each is entered just after a rising edge
  // ------------------------------------------------------------
  task bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask

  task wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task rd_chk(input logic [31:0] a, m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q & m, e)
  endtask

  // Hold sync events for n back-to-back cycles, then let them settle
  task ev(input logic [1:0] e, input int n);
    sync_ok <= e[0];
    sync_miss <= e[1];
    repeat (n) @(posedge clk);
    sync_ok <= 1'b0;
    sync_miss <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Mode fields and noise bits in, chosen mode and word lengths out
  task mode_chk(input logic [9:0] m, input logic [1:0] s, input logic [5:0] n, input logic [2:0] e);
    logic [4:0] ib, ob;
    surr <= s;
    wr(`DSM_OFS_NOISE, {26'h0, n});
    wr(`DSM_OFS_MODE, {22'h0, m});
    repeat (6) @(posedge clk);
    if (e == 3'h7) `CHK(op_mode == 3'h3 || op_mode == 3'h4, 1'b0)
    else `CHK(op_mode, e)
    ib = (m[5:4] == 2'h3) ? 5'd24 : 5'd16 + {2'h0, m[5:4], 1'b0};
    ob = (m[7:6] == 2'h3) ? 5'd24 : 5'd16 + {2'h0, m[7:6], 1'b0};
    rd_chk(`DSM_OFS_STATUS, 32'hFFC0_0000, {ob, ib, 22'h0});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    @(posedge clk);
    `CHK(init_busy, 1'b1)
    `CHK(omute, 1'b1)
    wr(`DSM_OFS_CTRL, 32'h2);
    while (init_busy !== 1'b0) @(posedge clk);
    rd_chk(`DSM_OFS_CTRL, 32'h3, 32'h1);
    rd_chk(`DSM_OFS_SETUP, 32'h3FF, 32'h10);
    wr(32'h40, 32'hFF);
    rd_chk(32'h40, 32'hFFFF_FFFF, 32'h0);
  endtask

  task t_setup;
    wr(`DSM_OFS_SETUP, 32'h132);
    wr(`DSM_OFS_SETUP, 32'h070);
    rd_chk(`DSM_OFS_SETUP, 32'h3FF, 32'h132);
    wr(`DSM_OFS_MODE, 32'h1);
    wr(`DSM_OFS_CTRL, 32'h0);
    rd_chk(`DSM_OFS_CTRL, 32'h3, 32'h0);
    wr(`DSM_OFS_SCALE, 32'hFFFF_FFFF);
    rd_chk(`DSM_OFS_SCALE, 32'hFFFF_FFFF, 32'h7F7F_7FFF);
  endtask

  task t_sync;
    ev(2'b01, 2);
    rd_chk(`DSM_OFS_STATUS, 32'h1C, OOS);
    ev(2'b01, 1);
    rd_chk(`DSM_OFS_STATUS, 32'h1C, DEC);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) stream_err <= 1'b1;
      else mute_n <= 1'b0;
      repeat (8) @(posedge clk);
      rd_chk(`DSM_OFS_STATUS, 32'h1C, LMU);
      `CHK(omute, 1'b1)
      stream_err <= 1'b0;
      mute_n <= 1'b1;
      repeat (8) @(posedge clk);
      rd_chk(`DSM_OFS_STATUS, 32'h1C, DEC);
    end
    ev(2'b10, 1);
    `CHK(locked, 1'b1)
    ev(2'b10, 1);
    rd_chk(`DSM_OFS_STATUS, 32'h1C, OOS);
    ev(2'b01, 3);
    ev(2'b10, 2);
    rd_chk(`DSM_OFS_STATUS, 32'h1C, OOS);
    ev(2'b01, 3);
    `CHK(locked, 1'b1)
    restart <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(`DSM_OFS_STATUS, 32'h1C, OOS);
    restart <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task t_modes;
    wr(`DSM_OFS_CTRL, 32'h1);
    mode_chk(10'h045, 2'h0, 6'h00, 3'h1);
    mode_chk(10'h099, 2'h2, 6'h00, 3'h1);
    mode_chk(10'h0E9, 2'h1, 6'h00, 3'h2);
    mode_chk(10'h031, 2'h0, 6'h00, 3'h2);
    mode_chk(10'h006, 2'h0, 6'h00, 3'h3);
    mode_chk(10'h003, 2'h0, 6'h00, 3'h4);
    mode_chk(10'h002, 2'h0, 6'h20, 3'h5);
    mode_chk(10'h205, 2'h0, 6'h00, 3'h1);
    mode_chk(10'h206, 2'h0, 6'h00, 3'h7);
    mode_chk(10'h000, 2'h0, 6'h00, 3'h4);
    deemph <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(deemph_on, 1'b1)
    // Pulse the preamble right after a frame start, so no frame start clears it
    while (frame_start !== 1'b1) @(posedge clk);
    preamble <= 1'b1;
    @(posedge clk);
    preamble <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(pti, 1'b1)
    `CHK(op_mode, 3'h2)
    `CHK(deemph_on, 1'b0)
  endtask

  task t_link;
    logic [35:0] pkt [2];
    logic [31:0] q;
    pkt[0] = 36'h9_ABCD_1234;
    pkt[1] = 36'h0_0000_0001;
    `CHK({cl_oe, cd_oe, fs_oe}, 3'b001)
    for (int k = 0; k < 2; k++) begin
      u_sub.send(pkt[k], 7 + 300 * k);
      @(posedge clk);
      q = 32'h0;
      for (int i = 0; i < 20 && q[0] !== 1'b1; i++) bus(1'b0, `DSM_OFS_STATUS, 32'h0, q);
      `CHK(q[0], 1'b1)
      rd_chk(`DSM_OFS_COMP1, 32'h3FFFF, {14'h0, pkt[k][35:18]});
      rd_chk(`DSM_OFS_COMP0, 32'h3FFFF, {14'h0, pkt[k][17:0]});
      rd_chk(`DSM_OFS_STATUS, 32'h1, 32'h0);
    end
  endtask

  task finish_test;
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_setup;
    t_sync;
    t_modes;
    t_link;
    finish_test;
  end
endmodule // tb
